// ### chain_regs_pkg.sv
/*
 Constants for the chain access and feature selection register bank.
 Assumes an 8-bit register port with a 7-bit address from the host serial port.
*/
package chain_regs_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] target_index_addr  = 7'h26;
    localparam logic [6:0] write_byte_addr    = 7'h27;
    localparam logic [6:0] command_addr       = 7'h28;
    localparam logic [6:0] read_byte_addr     = 7'h29;
    localparam logic [6:0] feature_first_addr = 7'h2A;
    localparam logic [6:0] feature_second_addr = 7'h2B;
    localparam logic [6:0] reserved_low_addr  = 7'h2C;
    localparam logic [6:0] reserved_high_addr = 7'h2F;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] zero_reset          = 8'h00;
    localparam logic [7:0] feature_second_reset = 8'h02;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int start_bit        = 0;
    localparam int code_lsb         = 1;
    localparam int zero_cross_bit   = 0;
    localparam int filter_lsb       = 1;
    localparam int divider_bit      = 4;
    localparam int ref_source_bit   = 5;
    localparam int limit_source_bit = 6;
    localparam int index_width      = 7;
    localparam logic [7:0] command_mask  = 8'h0F;
    localparam logic [7:0] feature1_mask = 8'h77;
    localparam logic [7:0] feature2_mask = 8'h03;
    localparam logic [7:0] index_mask    = 8'h7F;
    // ------------------------------------------------------------
    // Command codes and pad modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        cmd_reserved0 = 3'h0,
        cmd_read      = 3'h1,
        cmd_write     = 3'h2,
        cmd_alloc     = 3'h3,
        cmd_bcast_cfg = 3'h4,
        cmd_bcast_wr  = 3'h5
    } command_type;
    localparam logic [1:0] pad_opto   = 2'h2;
    localparam logic [1:0] pad_normal = 2'h3;
    // ------------------------------------------------------------
    // Filter times in microseconds and derived cycles at 50 MHz
    // ------------------------------------------------------------
    localparam int clk_mhz   = 50;
    localparam int filter_us_00 = 8;
    localparam int filter_us_01 = 6;
    localparam int filter_us_10 = 4;
    localparam int filter_us_11 = 2;
    localparam logic [9:0] filter_cycles_00 = 10'(filter_us_00 * clk_mhz);
    localparam logic [9:0] filter_cycles_01 = 10'(filter_us_01 * clk_mhz);
    localparam logic [9:0] filter_cycles_10 = 10'(filter_us_10 * clk_mhz);
    localparam logic [9:0] filter_cycles_11 = 10'(filter_us_11 * clk_mhz);
endpackage

// ### zero_cross_filter.sv
/*
 Zero-cross detect filter: a comparator level must hold steady for the
 selected time before the filtered output follows it.
 Assumes the raw level is already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module zero_cross_filter (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       enable,
    input  wire logic [1:0] filter_select,
    input  wire logic       raw_level,
    output logic            filtered
);
    logic [9:0] count;
    logic [9:0] limit;

    // ------------------------------------------------------------
    // Filter time selection
    // ------------------------------------------------------------
    always_comb begin
        case (filter_select)
            2'h0: limit = chain_regs_pkg::filter_cycles_00;
            2'h1: limit = chain_regs_pkg::filter_cycles_01;
            2'h2: limit = chain_regs_pkg::filter_cycles_10;
            default: limit = chain_regs_pkg::filter_cycles_11;
        endcase
    end

    // Restart the count whenever the level agrees with the output so glitches never pass
    always_ff @(posedge clk) begin
        if (reset || !enable) begin
            count    <= 10'h000;
            filtered <= 1'b0;
        end else if (raw_level == filtered) begin
            count <= 10'h000;
        end else if (count >= limit - 10'h001) begin
            filtered <= raw_level;
            count    <= 10'h000;
        end else begin
            count <= count + 10'h001;
        end
    end
endmodule
`default_nettype wire

// ### chain_access_feature_regs.sv
/*
 Chain access and feature selection register bank.
 Assumes the host serial port decoder gives one-cycle write and read strobes
 with a 7-bit address, and a chain link engine that reports done with read data.
*/
`timescale 1ns/1ps
`default_nettype none
module chain_access_feature_regs (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [6:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    input  wire logic [5:0] device_select,
    output logic            chain_start,
    output logic      [2:0] chain_op,
    output logic      [5:0] chain_device,
    output logic            chain_broadcast,
    output logic      [6:0] chain_index,
    output logic      [7:0] chain_wdata,
    input  wire logic       chain_done,
    input  wire logic       chain_rdata_valid,
    input  wire logic [7:0] chain_rdata,
    output logic            chain_busy,
    output logic            zero_cross_enable,
    output logic      [1:0] zero_cross_filter_select,
    input  wire logic       zero_cross_pin,
    output logic            zero_cross_detect,
    output logic            external_divider_enable,
    output logic            external_reference_select,
    output logic            external_limit_select,
    output logic      [1:0] converter_drive_pin_mode
);
    logic [7:0] target_index;
    logic [7:0] write_byte;
    logic [7:0] command;
    logic [7:0] read_byte;
    logic [7:0] feature_first;
    logic [7:0] feature_second;
    logic       zc_sync1;
    logic       zc_sync2;
    logic       zc_filtered;
    logic       valid_code;
    logic [7:0] next_rdata;
    logic       next_hit;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Reserved codes never launch, so a stray write cannot hang the link
    always_comb begin
        case (command[3:1])
            chain_regs_pkg::cmd_read,
            chain_regs_pkg::cmd_write,
            chain_regs_pkg::cmd_alloc,
            chain_regs_pkg::cmd_bcast_cfg,
            chain_regs_pkg::cmd_bcast_wr: valid_code = 1'b1;
            default: valid_code = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Command register and transaction tracking
    // ------------------------------------------------------------
    // Done wins over a host write in the same cycle: the link owns it then
    always_ff @(posedge clk) begin
        if (reset) begin
            command     <= chain_regs_pkg::zero_reset;
            chain_busy  <= 1'b0;
            chain_start <= 1'b0;
        end else begin
            chain_start <= 1'b0;
            if (chain_busy && chain_done) begin
                command    <= chain_regs_pkg::zero_reset;
                chain_busy <= 1'b0;
            end else if (!chain_busy && command[chain_regs_pkg::start_bit]) begin
                if (valid_code) begin
                    chain_start <= 1'b1;
                    chain_busy  <= 1'b1;
                end else begin
                    command <= chain_regs_pkg::zero_reset;
                end
            end else if (!chain_busy && reg_write
                         && reg_addr == chain_regs_pkg::command_addr) begin
                command <= reg_wdata & chain_regs_pkg::command_mask;
            end
        end
    end

    // Operation details latched at launch so host edits cannot disturb a frame
    always_ff @(posedge clk) begin
        if (reset) begin
            chain_op        <= 3'h0;
            chain_device    <= 6'h00;
            chain_broadcast <= 1'b0;
            chain_index     <= 7'h00;
            chain_wdata     <= chain_regs_pkg::zero_reset;
        end else if (!chain_busy && command[chain_regs_pkg::start_bit] && valid_code) begin
            chain_op     <= command[3:1];
            chain_device <= device_select;
            chain_index  <= target_index[chain_regs_pkg::index_width-1:0];
            chain_wdata  <= write_byte;
            chain_broadcast <= (command[3:1] == chain_regs_pkg::cmd_bcast_wr)
                || (device_select == 6'h00);
        end
    end

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            target_index <= chain_regs_pkg::zero_reset;
            write_byte   <= chain_regs_pkg::zero_reset;
        end else if (reg_write) begin
            if (reg_addr == chain_regs_pkg::target_index_addr) begin
                target_index <= reg_wdata & chain_regs_pkg::index_mask;
            end
            if (reg_addr == chain_regs_pkg::write_byte_addr) begin
                write_byte <= reg_wdata;
            end
        end
    end

    // Link data must arrive no later than done so a poll sees final data
    always_ff @(posedge clk) begin
        if (reset) begin
            read_byte <= chain_regs_pkg::zero_reset;
        end else if (chain_busy && chain_rdata_valid
                     && chain_op == chain_regs_pkg::cmd_read) begin
            read_byte <= chain_rdata;
        end else if (reg_write && reg_addr == chain_regs_pkg::read_byte_addr) begin
            read_byte <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Feature selection registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            feature_first  <= chain_regs_pkg::zero_reset;
            feature_second <= chain_regs_pkg::feature_second_reset;
        end else if (reg_write) begin
            if (reg_addr == chain_regs_pkg::feature_first_addr) begin
                feature_first <= reg_wdata & chain_regs_pkg::feature1_mask;
            end
            if (reg_addr == chain_regs_pkg::feature_second_addr) begin
                feature_second <= reg_wdata & chain_regs_pkg::feature2_mask;
            end
        end
    end

    // Registered feature outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            zero_cross_enable         <= 1'b0;
            zero_cross_filter_select  <= 2'h0;
            external_divider_enable   <= 1'b0;
            external_reference_select <= 1'b0;
            external_limit_select     <= 1'b0;
            converter_drive_pin_mode  <= chain_regs_pkg::pad_opto;
        end else begin
            zero_cross_enable         <= feature_first[chain_regs_pkg::zero_cross_bit];
            zero_cross_filter_select  <= feature_first[chain_regs_pkg::filter_lsb +: 2];
            external_divider_enable   <= feature_first[chain_regs_pkg::divider_bit];
            external_reference_select <= feature_first[chain_regs_pkg::ref_source_bit];
            external_limit_select     <= feature_first[chain_regs_pkg::limit_source_bit];
            converter_drive_pin_mode  <= feature_second[1:0];
        end
    end

    // ------------------------------------------------------------
    // Zero-cross pin path
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            zc_sync1          <= 1'b0;
            zc_sync2          <= 1'b0;
            zero_cross_detect <= 1'b0;
        end else begin
            zc_sync1          <= zero_cross_pin;
            zc_sync2          <= zc_sync1;
            zero_cross_detect <= zc_filtered;
        end
    end

    zero_cross_filter filter_inst (
        .clk           (clk),
        .reset         (reset),
        .enable        (feature_first[chain_regs_pkg::zero_cross_bit]),
        .filter_select (feature_first[chain_regs_pkg::filter_lsb +: 2]),
        .raw_level     (zc_sync2),
        .filtered      (zc_filtered)
    );

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    // Reserved window reads zero and reports no hit
    always_comb begin
        next_hit   = 1'b1;
        next_rdata = chain_regs_pkg::zero_reset;
        case (reg_addr)
            chain_regs_pkg::target_index_addr:   next_rdata = target_index;
            chain_regs_pkg::write_byte_addr:     next_rdata = write_byte;
            chain_regs_pkg::command_addr:        next_rdata = command;
            chain_regs_pkg::read_byte_addr:      next_rdata = read_byte;
            chain_regs_pkg::feature_first_addr:  next_rdata = feature_first;
            chain_regs_pkg::feature_second_addr: next_rdata = feature_second;
            default:                             next_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= chain_regs_pkg::zero_reset;
            reg_hit   <= 1'b0;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
            reg_hit   <= next_hit;
        end
    end
endmodule
`default_nettype wire

// ### chain_regs_assertions.sv
/*
 Checker for the chain access and feature register bank.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module chain_regs_assertions (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_hit,
    input wire logic       chain_start,
    input wire logic [2:0] chain_op,
    input wire logic [5:0] chain_device,
    input wire logic       chain_broadcast,
    input wire logic       chain_done,
    input wire logic       chain_busy,
    input wire logic       zero_cross_enable,
    input wire logic [1:0] zero_cross_filter_select,
    input wire logic       external_divider_enable,
    input wire logic       external_reference_select,
    input wire logic       external_limit_select,
    input wire logic [1:0] converter_drive_pin_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // --------------------------------------------------------
    // Command launch
    // --------------------------------------------------------
    // Only a write into an idle link counts; a write right behind another is refused
    sequence s_cmd_wr;
        reg_write && reg_addr == chain_regs_pkg::command_addr && reg_wdata[0] && !chain_busy
            && !chain_start && !$past(reg_write && reg_addr == chain_regs_pkg::command_addr);
    endsequence
    property p_launch;
        s_cmd_wr ##0 (reg_wdata[3:1] inside {[3'h1:3'h5]})
            |-> ##2 chain_start && chain_op == $past(reg_wdata[3:1], 2);
    endproperty
    a_launch: assert property (p_launch) else $error("valid command not launched");
    property p_reserved_code;
        s_cmd_wr ##0 (reg_wdata[3:1] inside {3'h0, 3'h6, 3'h7}) |-> ##1 (!chain_start) [*3];
    endproperty
    a_reserved_code: assert property (p_reserved_code)
        else $error("reserved code launched");
    property p_start;
        chain_start |-> chain_busy ##1 !chain_start;
    endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_done;
        chain_busy && chain_done |=> !chain_busy;
    endproperty
    a_done: assert property (p_done) else $error("busy not cleared by done");
    property p_bcast;
        chain_start |-> chain_broadcast == (chain_op == 3'h5 || chain_device == 6'h00);
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");
    // --------------------------------------------------------
    // Features and map
    // --------------------------------------------------------
    property p_feat1;
        reg_write && reg_addr == chain_regs_pkg::feature_first_addr |-> ##2
            {external_limit_select, external_reference_select, external_divider_enable,
             zero_cross_filter_select, zero_cross_enable}
            == {$past(reg_wdata[6:4], 2), $past(reg_wdata[2:0], 2)};
    endproperty
    a_feat1: assert property (p_feat1)
        else $error("feature outputs wrong");
    property p_feat2;
        reg_write && reg_addr == chain_regs_pkg::feature_second_addr
            |-> ##2 converter_drive_pin_mode == $past(reg_wdata[1:0], 2);
    endproperty
    a_feat2: assert property (p_feat2) else $error("pad mode wrong");
    property p_pad_reset;
        $fell(reset) |-> converter_drive_pin_mode == chain_regs_pkg::pad_opto;
    endproperty
    a_pad_reset: assert property (p_pad_reset) else $error("pad mode reset wrong");
    property p_reserved;
        reg_read && reg_addr inside {[7'h2C:7'h2F]} |=> !reg_hit && reg_rdata == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved place answered");
    property p_mapped;
        reg_read && reg_addr inside {[7'h26:7'h2B]} |=> reg_hit;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped place missed");
endmodule
bind chain_access_feature_regs chain_regs_assertions chk_u (.*);
`default_nettype wire

// ### chain_link_model.sv
/*
 Behavioural chain link engine standing behind the register bank.
 Assumes one operation at a time, launched by a one-cycle start pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module chain_link_model #(parameter int latency = 6) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       chain_start,
    input  wire logic [2:0] chain_op,
    input  wire logic [6:0] chain_index,
    output logic            chain_done,
    output logic            chain_rdata_valid,
    output logic      [7:0] chain_rdata
);
    int count;
    // Read byte lands one cycle before done; outside that the data line keeps toggling
    always_ff @(posedge clk) begin
        chain_done <= 1'b0;
        chain_rdata_valid <= 1'b0;
        chain_rdata <= ~chain_rdata;
        if (reset) begin
            count <= 0;
            chain_rdata <= 8'h00;
        end else if (chain_start) begin
            count <= latency;
        end else if (count > 0) begin
            count <= count - 1;
            if (count == 2 && chain_op == 3'h1) begin
                chain_rdata_valid <= 1'b1;
                chain_rdata <= {1'b1, chain_index};
            end
            if (count == 1) begin
                chain_done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test_chain_access_feature_regs.sv
/*
 Self-checking testbench for the chain register bank.
 Assumes the host port strobes are one cycle wide and taken on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module test_chain_access_feature_regs;
    logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, zero_cross_pin = 0;
    logic reg_hit, chain_start, chain_broadcast, chain_done, chain_rdata_valid, chain_busy;
    logic zero_cross_enable, zero_cross_detect, external_divider_enable;
    logic external_reference_select, external_limit_select;
    logic [6:0] reg_addr = 0, chain_index;
    logic [7:0] reg_wdata = 0, reg_rdata, chain_wdata, chain_rdata, got;
    logic [5:0] device_select = 0, chain_device;
    logic [2:0] chain_op;
    logic [1:0] zero_cross_filter_select, converter_drive_pin_mode;
    logic [7:0] feat [5] = '{8'h77, 8'h00, 8'h13, 8'h25, 8'h41};
    int   fails = 0, n_tests = 0, k;
    chain_access_feature_regs dut_u (.*);
    chain_link_model link_u (.*);
    always #10 clk = ~clk;
    // ---------------------------------------------------------
    // Host port tasks
    // ---------------------------------------------------------
    task automatic end_sim();
        if (fails == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Strobe drops then one idle edge, so back-to-back calls never double-drive it
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        ticks(1);
        reg_write = 1'b0;
        ticks(1);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e, input logic h);
        reg_addr = a;
        reg_read = 1'b1;
        ticks(1);
        reg_read = 1'b0;
        chk("read data", e, reg_rdata);
        chk("hit", {7'h00, h}, {7'h00, reg_hit});
        ticks(1);
    endtask
    // Cut a hang short
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    initial begin
        ticks(6);
        reset = 1'b0;
        for (int i = 0; i < 6; i++) rdc(7'h26 + 7'(i), (i == 5) ? 8'h02 : 8'h00, 1'b1);
        chk("pad", 8'h02, {6'h00, converter_drive_pin_mode});
        for (int i = 0; i < 4; i++) begin
            wr(7'h2C + 7'(i), 8'hFF);
            rdc(7'h2C + 7'(i), 8'h00, 1'b0);
        end
        wr(7'h26, 8'hFF);
        rdc(7'h26, 8'h7F, 1'b1);
        wr(7'h27, 8'hFF);
        rdc(7'h27, 8'hFF, 1'b1);
        wr(7'h2B, 8'hFF);
        chk("pad", 8'h03, {6'h00, converter_drive_pin_mode});
        rdc(7'h2B, 8'h03, 1'b1);
        // Reserved feature bits are set on purpose and must read back clear
        for (int i = 0; i < 5; i++) begin
            wr(7'h2A, feat[i] | 8'h88);
            got = {1'b0, external_limit_select, external_reference_select,
                   external_divider_enable, 1'b0, zero_cross_filter_select, zero_cross_enable};
            chk("features", feat[i], got);
            rdc(7'h2A, feat[i], 1'b1);
        end
        wr(7'h2A, 8'h07);
        zero_cross_pin = 1'b1;
        ticks(60);
        chk("zero cross early", 8'h00, {7'h00, zero_cross_detect});
        ticks(60);
        chk("zero cross", 8'h01, {7'h00, zero_cross_detect});
        // Every command code, reserved 000 too; code 1 goes out with the all-zero device
        for (int c = 0; c < 8; c++) begin
            device_select = (c == 1) ? 6'h00 : 6'h05;
            wr(7'h26, {1'b0, 7'(c * 9)});
            wr(7'h27, 8'(c * 17));
            wr(7'h28, {4'h0, 3'(c), 1'b1});
            k = 0;
            while (chain_start !== 1'b1 && k < 4) begin
                ticks(1);
                k++;
            end
            if (c > 0 && c < 6) begin
                chk("op", 8'(c), {5'h00, chain_op});
                chk("device", (c == 1) ? 8'h00 : 8'h05, {2'h0, chain_device});
                chk("index", 8'(c * 9), {1'b0, chain_index});
                chk("wbyte", 8'(c * 17), chain_wdata);
                chk("bcast", {7'h00, c == 1 || c == 5}, {7'h00, chain_broadcast});
                if (c == 2) wr(7'h28, 8'h03);
                k = 0;
                while (chain_busy === 1'b1 && k < 20) begin
                    ticks(1);
                    k++;
                end
                rdc(7'h28, 8'h00, 1'b1);
                if (c == 1) rdc(7'h29, {1'b1, 7'(c * 9)}, 1'b1);
            end else begin
                chk("no start", 8'h00, {7'h00, chain_start});
                rdc(7'h28, 8'h00, 1'b1);
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
